// *** rtl/rbmc_defs.svh ***
// Timing-free constants for the reset and boot-mode capture block.
// Assumes inclusion by bare name from rtl/ and verif/ files.
`ifndef RBMC_DEFS_SVH
`define RBMC_DEFS_SVH

// Number of mode-select pins and the number of bootstrap modes they code.
`define RBMC_MODE_PINS 3
`define RBMC_MODE_COUNT 8

// Reset values of the captured mode and its one-hot decode.
`define RBMC_MODE_RST 3'h0
`define RBMC_SEL_RST 8'h01

// Bit positions of the three mode-select pins in the pin vector.
`define RBMC_BIT_A 0
`define RBMC_BIT_B 1
`define RBMC_BIT_C 2

// Output enable level for an idle (undriven) pin, active low.
`define RBMC_OE_OFF 3'h7

`endif

// *** rtl/rbmc_pkg.sv ***
// Types shared by the reset and boot-mode capture block.
// Assumes rbmc_defs.svh sits in the same folder.
`default_nettype none
`include "rbmc_defs.svh"

package rbmc_pkg;

  // Sequencer states: held in reset, bootstrapping, running.
  typedef enum logic [1:0] {
    RBMC_HOLD,
    RBMC_BOOT,
    RBMC_RUN
  } rbmc_state_t;

  // Captured boot mode, one bit per mode-select pin.
  typedef logic [`RBMC_MODE_PINS-1:0] rbmc_mode_t;

  // One-hot bootstrap mode selection.
  typedef logic [`RBMC_MODE_COUNT-1:0] rbmc_sel_t;

endpackage
`default_nettype wire

// *** rtl/rbmc_pin_mux.sv ***
// Pin sharing for the three mode-select pins.
// Assumes the pins are synchronous inputs and the caller drives mode_duty.
`timescale 1ns/1ns
`default_nettype none
`include "rbmc_defs.svh"

module rbmc_pin_mux (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Ownership: high while the pins serve as mode selects.
  input wire logic mode_duty,
  // General-purpose side.
  input wire logic [`RBMC_MODE_PINS-1:0] gpio_out,
  input wire logic [`RBMC_MODE_PINS-1:0] gpio_dir,
  output logic [`RBMC_MODE_PINS-1:0] gpio_in,
  // Pad side.
  input wire logic [`RBMC_MODE_PINS-1:0] pin_in,
  output logic [`RBMC_MODE_PINS-1:0] pin_out,
  output logic [`RBMC_MODE_PINS-1:0] pin_oe_n
);

  // Each pin is its own flop slice; while on mode duty the pad is never
  // driven so the board strap alone sets the level.
  genvar i;
  generate
    for (i = 0; i < `RBMC_MODE_PINS; i = i + 1) begin : g_pin
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          pin_out[i] <= 1'b0;
          pin_oe_n[i] <= 1'b1;
          gpio_in[i] <= 1'b0;
        end else begin
          pin_out[i] <= gpio_out[i];
          pin_oe_n[i] <= mode_duty | ~gpio_dir[i];
          gpio_in[i] <= pin_in[i];
        end
      end
    end
  endgenerate

  AST_DUTY_UNDRIVEN: assert property (@(posedge clk) disable iff (reset)
    $past(mode_duty) |-> pin_oe_n == `RBMC_OE_OFF)
    else $error("Mode pin driven while on mode duty.");

  AST_GPIO_HANDOVER: assert property (@(posedge clk) disable iff (reset)
    !mode_duty ##1 1'b1 |-> pin_oe_n == ~$past(gpio_dir))
    else $error("Pin enable does not follow direction after bootstrap.");

endmodule
`default_nettype wire

// *** rtl/rbmc_top.sv ***
// Chip reset sequencing and boot-mode capture.
// Assumes every input is synchronous to clk; reset is the power-on reset.
`timescale 1ns/1ns
`default_nettype none
`include "rbmc_defs.svh"

// Functional notes
// - Three mode pins choose one of eight modes.
// - After bootstrap, mode pins become general I/O.
// - External reset low holds device in reset.
// - External reset release captures mode pins as mode.
// - Reset output follows any active reset source.
module rbmc_top (
  // Clock and power-on reset.
  input wire logic clk,
  input wire logic reset,
  // Reset sources.
  input wire logic ext_reset_n,
  input wire logic low_voltage_det,
  input wire logic sw_reset_req,
  input wire logic watchdog_timeout_source,
  // Core handshake.
  input wire logic boot_done,
  output logic core_reset_q,
  output logic bootstrap_active_q,
  output rbmc_pkg::rbmc_mode_t boot_mode_q,
  output rbmc_pkg::rbmc_sel_t boot_mode_sel_q,
  // Reset indication pin.
  output logic reset_indicator_out,
  // General-purpose view of the mode pins.
  input wire logic [`RBMC_MODE_PINS-1:0] gpio_out,
  input wire logic [`RBMC_MODE_PINS-1:0] gpio_dir,
  output logic [`RBMC_MODE_PINS-1:0] gpio_in,
  // Mode pins: bit a, bit b, bit c in positions 0, 1, 2.
  input wire logic [`RBMC_MODE_PINS-1:0] boot_pin_io_in,
  output logic [`RBMC_MODE_PINS-1:0] boot_pin_io_out,
  output logic [`RBMC_MODE_PINS-1:0] boot_pin_io_oe_n
);

  // Decodes a mode code to its one-hot bootstrap selection.
  function automatic rbmc_pkg::rbmc_sel_t rbmc_decode(
    input rbmc_pkg::rbmc_mode_t mode);
    rbmc_pkg::rbmc_sel_t sel;
    sel = '0;
    sel[mode] = 1'b1;
    return sel;
  endfunction

  // Sequencer state, sampled external reset and the raw mode-pin straps.
  rbmc_pkg::rbmc_state_t state_q;
  rbmc_pkg::rbmc_state_t state_d;
  logic ext_q;
  logic any_src;
  logic ext_release;
  logic mode_duty;
  rbmc_pkg::rbmc_mode_t strap;

  // Name the strap bits explicitly so the pin order is fixed in one place.
  assign strap[`RBMC_BIT_A] = boot_pin_io_in[`RBMC_BIT_A];
  assign strap[`RBMC_BIT_B] = boot_pin_io_in[`RBMC_BIT_B];
  assign strap[`RBMC_BIT_C] = boot_pin_io_in[`RBMC_BIT_C];

  // Any of the four sources keeps the device in reset.
  assign any_src = ~ext_reset_n | low_voltage_det | sw_reset_req
                   | watchdog_timeout_source;
  // A release is the pin high now after a low level on the previous edge;
  // a pin held high through power-on reset therefore also counts as one.
  assign ext_release = ext_reset_n & ~ext_q;

  // Previous level of the external reset, used to find its release.
  // It resets to the asserted level so that power-on counts as a release.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_reset_n;
    end
  end

  // Sequencer: any source forces hold, release starts the bootstrap.
  always_comb begin
    state_d = state_q;
    case (state_q)
      rbmc_pkg::RBMC_HOLD: begin
        if (!any_src) begin
          state_d = rbmc_pkg::RBMC_BOOT;
        end
      end
      rbmc_pkg::RBMC_BOOT: begin
        if (boot_done) begin
          state_d = rbmc_pkg::RBMC_RUN;
        end
      end
      rbmc_pkg::RBMC_RUN: begin
        state_d = rbmc_pkg::RBMC_RUN;
      end
      default: begin
        state_d = rbmc_pkg::RBMC_HOLD;
      end
    endcase
    if (any_src) begin
      state_d = rbmc_pkg::RBMC_HOLD;
    end
  end

  // State register. Power-on reset parks it in hold, so the sources are
  // looked at before any bootstrap can start.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= rbmc_pkg::RBMC_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // The pins stay mode selects until the bootstrap has finished.
  assign mode_duty = (state_d != rbmc_pkg::RBMC_RUN);

  // Core reset and the reset pin both follow the sources directly, so a
  // short pulse on any source is never missed.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_reset_q <= 1'b1;
      reset_indicator_out <= 1'b1;
      bootstrap_active_q <= 1'b1;
    end else begin
      core_reset_q <= any_src;
      reset_indicator_out <= any_src;
      bootstrap_active_q <= mode_duty;
    end
  end

  // The mode is taken only on the external release; software, watchdog
  // and low-voltage resets rerun the bootstrap with the mode already held.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      boot_mode_q <= `RBMC_MODE_RST;
      boot_mode_sel_q <= `RBMC_SEL_RST;
    end else if (ext_release) begin
      boot_mode_q <= strap;
      boot_mode_sel_q <= rbmc_decode(strap);
    end
  end

  // Pin ownership and pad registers.
  rbmc_pin_mux u_pin_mux (
    .clk(clk),
    .reset(reset),
    .mode_duty(mode_duty),
    .gpio_out(gpio_out),
    .gpio_dir(gpio_dir),
    .gpio_in(gpio_in),
    .pin_in(boot_pin_io_in),
    .pin_out(boot_pin_io_out),
    .pin_oe_n(boot_pin_io_oe_n)
  );

  // Checks on the sequencer and the capture. They read internal nets such
  // as the sampled external reset, so they sit here rather than in a
  // separate checker; the first edge after power-on reset is skipped
  // where a check looks back into the reset itself.
  AST_ONE_OF_EIGHT: assert property (@(posedge clk) disable iff (reset)
    boot_mode_sel_q == rbmc_decode(boot_mode_q)
    && $countones(boot_mode_sel_q) == 1)
    else $error("Mode selection is not the one-hot of the mode.");

  AST_EXT_HOLDS: assert property (@(posedge clk) disable iff (reset)
    !ext_reset_n |=> core_reset_q && !bootstrap_active_q == 1'b0)
    else $error("External reset low did not hold the core in reset.");

  AST_CAPTURE: assert property (@(posedge clk) disable iff (reset)
    ext_reset_n && !ext_q |=> boot_mode_q == $past(boot_pin_io_in))
    else $error("Mode not captured at external reset release.");

  AST_SOURCES: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> reset_indicator_out == $past(any_src)
    && core_reset_q == reset_indicator_out)
    else $error("Reset output does not follow the reset sources.");

  AST_MODE_STABLE: assert property (@(posedge clk) disable iff (reset)
    ext_q ##1 ext_q |-> $stable(boot_mode_q))
    else $error("Captured mode changed without an external release.");

  AST_BOOT_ORDER: assert property (@(posedge clk) disable iff (reset)
    state_q == rbmc_pkg::RBMC_HOLD && !any_src |=> bootstrap_active_q
    ##0 state_q == rbmc_pkg::RBMC_BOOT)
    else $error("Release did not enter the bootstrap.");

  AST_SEL_FROM_PINS: assert property (@(posedge clk) disable iff (reset)
    ext_reset_n && !ext_q |=>
    boot_mode_sel_q == (8'h01 << $past(boot_pin_io_in)))
    else $error("Mode selection does not match the captured pins.");

  AST_PINS_ON_DUTY: assert property (@(posedge clk) disable iff (reset)
    bootstrap_active_q |-> boot_pin_io_oe_n == `RBMC_OE_OFF)
    else $error("Mode pin driven while the bootstrap runs.");

  AST_DONE_ENDS_BOOT: assert property (@(posedge clk) disable iff (reset)
    $fell(bootstrap_active_q) |-> $past(boot_done) && !$past(any_src))
    else $error("Pins left mode duty without a finished bootstrap.");

  AST_HOLD_IN_BOOT: assert property (@(posedge clk) disable iff (reset)
    core_reset_q |-> bootstrap_active_q)
    else $error("Core in reset while the pins left mode duty.");

  AST_DONE_IGNORED: assert property (@(posedge clk) disable iff (reset)
    any_src && boot_done |=> bootstrap_active_q && core_reset_q)
    else $error("Bootstrap finished while a reset source was active.");

  AST_SEL_STABLE: assert property (@(posedge clk) disable iff (reset)
    ext_reset_n && ext_q |=> $stable(boot_mode_sel_q))
    else $error("Mode selection changed without an external release.");

endmodule
`default_nettype wire

// *** verif/rbmc_board.sv ***
// Board model: reset switch, test-reset line and mode-pin straps.
// Assumes the bench moves its controls just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module rbmc_board (
  // Controls from the bench.
  input wire logic press,
  input wire logic keep_debug,
  input wire logic [2:0] strap,
  // Device pins.
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe_n,
  output logic ext_reset_n,
  output logic trst_n,
  output logic [2:0] pin_level
);
  // Test reset falls with the chip reset unless a debug session is kept.
  assign ext_reset_n = !press;
  assign trst_n = !(press && !keep_debug);
  // An idle pin shows its strap resistor, so no stale drive lingers.
  assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & strap);
endmodule
`default_nettype wire

// *** verif/reset_and_boot_mode_capture_tb_top.sv ***
// Self-checking bench for the reset and boot-mode capture block.
// Assumes rbmc_defs.svh is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "rbmc_defs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module reset_and_boot_mode_capture_tb_top;
  logic clk, reset, press, keep_debug, lvd, sw, wdog, boot_done;
  logic ext_reset_n, trst_n, core_q, boot_q, ind;
  logic [2:0] strap, gout, gdir, gin, lvl, pout, oe_n;
  rbmc_pkg::rbmc_mode_t mode;
  rbmc_pkg::rbmc_sel_t sel;
  int n_errors = 0;
  int checks_done = 0;
  // Each row holds a strap code above its expected one-hot selection.
  logic [10:0] rows [8] = '{11'h001, 11'h102, 11'h204, 11'h308,
    11'h410, 11'h520, 11'h640, 11'h780};
  rbmc_board board (.press(press), .keep_debug(keep_debug), .strap(strap),
    .pin_out(pout), .pin_oe_n(oe_n), .ext_reset_n(ext_reset_n),
    .trst_n(trst_n), .pin_level(lvl));
  rbmc_top dut (.clk(clk), .reset(reset), .ext_reset_n(ext_reset_n),
    .low_voltage_det(lvd), .sw_reset_req(sw),
    .watchdog_timeout_source(wdog), .boot_done(boot_done),
    .core_reset_q(core_q), .bootstrap_active_q(boot_q), .boot_mode_q(mode),
    .boot_mode_sel_q(sel), .reset_indicator_out(ind), .gpio_out(gout),
    .gpio_dir(gdir), .gpio_in(gin), .boot_pin_io_in(lvl),
    .boot_pin_io_out(pout), .boot_pin_io_oe_n(oe_n));
  // Clock of 50 ns period.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Inputs move 1 ns after an edge so no race with sampling exists.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence: table of straps, then handover, sources and reset.
  initial begin
    {reset, press, keep_debug, lvd, sw, wdog, boot_done} = 7'h40;
    {strap, gout, gdir} = 9'h14d;
    step(12);
    `CHK({sel, oe_n}, {`RBMC_SEL_RST, `RBMC_OE_OFF})
    reset = 1'b0;
    for (int i = 0; i < 8; i++) begin
      strap = rows[i][10:8];
      press = 1'b1;
      step(3);
      `CHK({core_q, ind, trst_n}, 3'h6)
      press = 1'b0;
      step(3);
      strap = ~strap;
      step(1);
      `CHK({mode, sel}, rows[i])
      `CHK({core_q, ind, boot_q, oe_n}, 6'h0f)
      $display("test strap %0d done", i);
    end
    boot_done = 1'b1;
    for (int w = 0; w < 10 && boot_q !== 1'b0; w++)
      step(1);
    if (boot_q !== 1'b0) begin
      n_errors++;
      end_of_test();
    end
    boot_done = 1'b0;
    strap = 3'h7;
    step(2);
    `CHK({oe_n, pout}, 6'h11)
    `CHK(gin, 3'h3)
    $display("test handover done");
    for (int k = 0; k < 3; k++) begin
      // A done request while a source stands must be ignored.
      {wdog, sw, lvd, boot_done} = {3'h1 << k, 1'b1};
      step(2);
      `CHK({core_q, ind, oe_n}, 5'h1f)
      {wdog, sw, lvd, boot_done} = 4'h0;
      step(2);
      `CHK({ind, boot_q, mode}, 5'h0f)
    end
    $display("test sources done");
    keep_debug = 1'b1;
    press = 1'b1;
    step(1);
    `CHK(trst_n, 1'b1)
    press = 1'b0;
    reset = 1'b1;
    strap = 3'h6;
    step(1);
    `CHK({mode, sel, ind}, 12'h003)
    reset = 1'b0;
    step(1);
    `CHK({mode, sel, ind, boot_q}, {3'h6, 8'h40, 2'h1})
    $display("test second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
